// >>> logic/ieu_core.sv
// Instruction execute unit: executes one decoded instruction per request
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ieu_consts.svh"
module ieu_core (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic        instr_valid_i,
	input  wire logic [4:0]  instr_op_i,
	input  wire logic [6:0]  instr_addr_i,
	input  wire logic [7:0]  instr_imm_i,
	input  wire logic [10:0] instr_target_i,
	input  wire logic        irq_pending_i,
	input  wire logic        wdt_timeout_i,
	input  wire logic [2:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	output logic             ready_o,
	output logic      [10:0] pc_o,
	output logic      [7:0]  acc_o,
	output logic             sleep_o,
	output logic             wdt_clear_o,
	output logic             irq_ack_o
);
	////////////////////////////////////////////////////////////////////////////////
	ieu_pkg::ieu_state_t state_q;
	ieu_pkg::ieu_state_t state_d;
	ieu_pkg::ieu_op_t    op;
	logic [7:0]  acc_q;
	logic [7:0]  acc_d;
	logic [10:0] pc_q;
	logic [10:0] pc_d;
	logic        z_q;
	logic        z_d;
	logic        c_q;
	logic        c_d;
	logic        ac_q;
	logic        to_q;
	logic        pdf_q;
	logic        emi_q;
	logic        interrupt_exit_q;
	logic        take;
	logic        mem_we;
	logic [7:0]  mem_wd;
	logic [7:0]  mem_rd;
	logic        stk_push;
	logic        stk_pop;
	logic [10:0] stk_top;
	logic        service;
	logic        wake;
	logic [8:0]  daa_sum;
	logic        daa_lo;
	logic        daa_hi;

	function automatic logic is_zero(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	assign op = ieu_pkg::ieu_op_t'(instr_op_i);
	// Requests made while busy or asleep are dropped, not queued
	assign take = instr_valid_i && (state_q == ieu_pkg::ST_READY);
	assign service = interrupt_exit_q && irq_pending_i && emi_q;
	assign wake = (reg_wr_i && (reg_addr_i == `IEU_REG_CTRL)
		&& reg_wdata_i[`IEU_CTRL_WAKE]) || irq_pending_i;

	ieu_dmem u_dmem (
		.sys_clk_i (sys_clk_i),
		.addr_i    (instr_addr_i),
		.we_i      (mem_we),
		.wdata_i   (mem_wd),
		.rdata_o   (mem_rd)
	);

	ieu_stack u_stack (
		.sys_clk_i   (sys_clk_i),
		.reset_i     (reset_i),
		.push_i      (stk_push),
		.pop_i       (stk_pop),
		.push_data_i (pc_q),
		.top_o       (stk_top)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decimal adjust correction
	assign daa_lo = (acc_q[3:0] > `IEU_DAA_LIMIT) || ac_q;
	assign daa_hi = (acc_q[7:4] > `IEU_DAA_LIMIT) || c_q;
	assign daa_sum = {1'b0, acc_q}
		+ {1'b0, (daa_hi ? `IEU_DAA_FIX : 4'h0), (daa_lo ? `IEU_DAA_FIX : 4'h0)};

	always_comb begin
		acc_d = acc_q;
		pc_d = pc_q;
		z_d = z_q;
		c_d = c_q;
		mem_we = 1'b0;
		mem_wd = 8'h00;
		stk_push = 1'b0;
		stk_pop = 1'b0;
		state_d = state_q;
		case (state_q)
			ieu_pkg::ST_READY: begin
				if (take) begin
					pc_d = pc_q + 11'h001;
					case (op)
						ieu_pkg::INVERT_MEMORY: begin
							mem_we = 1'b1;
							mem_wd = ~mem_rd;
							z_d = is_zero(~mem_rd);
						end
						ieu_pkg::INVERT_TO_ACCUMULATOR: begin
							acc_d = ~mem_rd;
							z_d = is_zero(~mem_rd);
						end
						ieu_pkg::DECIMAL_ADJUST: begin
							mem_we = 1'b1;
							mem_wd = daa_sum[7:0];
							c_d = c_q | daa_hi | daa_sum[8];
						end
						ieu_pkg::SUBTRACT_ONE_MEMORY: begin
							mem_we = 1'b1;
							mem_wd = mem_rd - 8'h01;
							z_d = is_zero(mem_rd - 8'h01);
						end
						ieu_pkg::SUBTRACT_ONE_TO_ACC: begin
							acc_d = mem_rd - 8'h01;
							z_d = is_zero(mem_rd - 8'h01);
						end
						ieu_pkg::ADD_ONE_MEMORY: begin
							mem_we = 1'b1;
							mem_wd = mem_rd + 8'h01;
							z_d = is_zero(mem_rd + 8'h01);
						end
						ieu_pkg::ADD_ONE_TO_ACC: begin
							acc_d = mem_rd + 8'h01;
							z_d = is_zero(mem_rd + 8'h01);
						end
						ieu_pkg::POWER_DOWN: begin
							state_d = ieu_pkg::ST_SLEEP;
						end
						ieu_pkg::BRANCH_ABSOLUTE: begin
							pc_d = instr_target_i;
							state_d = ieu_pkg::ST_DUMMY;
						end
						ieu_pkg::COPY_MEM_TO_ACC: acc_d = mem_rd;
						ieu_pkg::COPY_IMM_TO_ACC: acc_d = instr_imm_i;
						ieu_pkg::COPY_ACC_TO_MEM: begin
							mem_we = 1'b1;
							mem_wd = acc_q;
						end
						ieu_pkg::OR_MEM_TO_ACC: begin
							acc_d = acc_q | mem_rd;
							z_d = is_zero(acc_q | mem_rd);
						end
						ieu_pkg::OR_IMM_TO_ACC: begin
							acc_d = acc_q | instr_imm_i;
							z_d = is_zero(acc_q | instr_imm_i);
						end
						ieu_pkg::OR_INTO_MEMORY: begin
							mem_we = 1'b1;
							mem_wd = acc_q | mem_rd;
							z_d = is_zero(acc_q | mem_rd);
						end
						ieu_pkg::POP_TO_COUNTER, ieu_pkg::INTERRUPT_EXIT: begin
							stk_pop = 1'b1;
							pc_d = stk_top;
							state_d = ieu_pkg::ST_DUMMY;
						end
						ieu_pkg::POP_LOAD_ACC: begin
							stk_pop = 1'b1;
							pc_d = stk_top;
							acc_d = instr_imm_i;
							state_d = ieu_pkg::ST_DUMMY;
						end
						ieu_pkg::ROTATE_LEFT: begin
							mem_we = 1'b1;
							mem_wd = {mem_rd[6:0], mem_rd[7]};
						end
						ieu_pkg::ROTATE_LEFT_TO_ACC: begin
							acc_d = {mem_rd[6:0], mem_rd[7]};
						end
						default: begin
						end
					endcase
				end
			end
			ieu_pkg::ST_DUMMY: begin
				state_d = ieu_pkg::ST_READY;
				if (service) begin
					stk_push = 1'b1;
					pc_d = `IEU_IRQ_VECTOR;
				end
			end
			ieu_pkg::ST_SLEEP: begin
				if (wake) begin
					state_d = ieu_pkg::ST_READY;
				end
			end
			default: state_d = ieu_pkg::ST_READY;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencing
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_q <= ieu_pkg::ST_READY;
			ready_o <= 1'b1;
			sleep_o <= 1'b0;
		end else begin
			state_q <= state_d;
			ready_o <= (state_d == ieu_pkg::ST_READY);
			sleep_o <= (state_d == ieu_pkg::ST_SLEEP);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			interrupt_exit_q <= 1'b0;
			irq_ack_o <= 1'b0;
		end else begin
			interrupt_exit_q <= take && (op == ieu_pkg::INTERRUPT_EXIT);
			irq_ack_o <= (state_q == ieu_pkg::ST_DUMMY) && service;
		end
	end

	// Datapath registers: sleeping simply holds them, so contents survive
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			acc_q <= `IEU_ACC_RST;
			pc_q <= `IEU_PC_RST;
		end else begin
			acc_q <= acc_d;
			pc_q <= pc_d;
		end
	end
	assign acc_o = acc_q;
	assign pc_o = pc_q;

	// Arithmetic flags; a software write loses to an instruction in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			z_q <= 1'b0;
			c_q <= 1'b0;
			ac_q <= 1'b0;
		end else if (take) begin
			z_q <= z_d;
			c_q <= c_d;
		end else if (reg_wr_i && (reg_addr_i == `IEU_REG_STATUS)) begin
			z_q <= reg_wdata_i[`IEU_ST_Z];
			c_q <= reg_wdata_i[`IEU_ST_C];
			ac_q <= reg_wdata_i[`IEU_ST_AC];
		end
	end

	// Global interrupt enable
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			emi_q <= 1'b0;
		end else if ((state_q == ieu_pkg::ST_DUMMY) && service) begin
			emi_q <= 1'b0;
		end else if (take && (op == ieu_pkg::INTERRUPT_EXIT)) begin
			emi_q <= 1'b1;
		end else if (reg_wr_i && (reg_addr_i == `IEU_REG_STATUS)) begin
			emi_q <= reg_wdata_i[`IEU_ST_EMI];
		end
	end

	// Watchdog side: expiry sets win over the power-down clear
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			to_q <= 1'b0;
			pdf_q <= 1'b0;
			wdt_clear_o <= 1'b0;
		end else begin
			wdt_clear_o <= take && (op == ieu_pkg::POWER_DOWN);
			if (wdt_timeout_i) begin
				to_q <= 1'b1;
			end else if (take && (op == ieu_pkg::POWER_DOWN)) begin
				to_q <= 1'b0;
			end
			if (take && (op == ieu_pkg::POWER_DOWN)) begin
				pdf_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register port
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
		end else if (!reg_rd_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_addr_i == `IEU_REG_STATUS) begin
			reg_rdata_o <= {2'b00, emi_q, pdf_q, to_q, ac_q, c_q, z_q};
		end else if (reg_addr_i == `IEU_REG_ACC) begin
			reg_rdata_o <= acc_q;
		end else if (reg_addr_i == `IEU_REG_PC_LO) begin
			reg_rdata_o <= pc_q[7:0];
		end else if (reg_addr_i == `IEU_REG_PC_HI) begin
			reg_rdata_o <= {5'h00, pc_q[10:8]};
		end else if (reg_addr_i == `IEU_REG_CTRL) begin
			reg_rdata_o <= {6'h00, ready_o, sleep_o};
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_INVERT_ACC: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::INVERT_TO_ACCUMULATOR
		|=> acc_q == ~$past(mem_rd) && z_q == ($past(mem_rd) == 8'hFF) && c_q == $past(c_q))
		else $error("invert to accumulator wrong");
	AST_DAA_VALUE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::DECIMAL_ADJUST && acc_q[3:0] > `IEU_DAA_LIMIT && !c_q
		&& acc_q[7:4] < `IEU_DAA_LIMIT |-> mem_we && mem_wd == acc_q + {4'h0, `IEU_DAA_FIX} && !c_d)
		else $error("decimal adjust result wrong");
	AST_DAA_FLAGS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::DECIMAL_ADJUST |=> z_q == $past(z_q) && acc_q == $past(acc_q))
		else $error("decimal adjust touched other state");
	AST_SUB1_ACC: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::SUBTRACT_ONE_TO_ACC |-> !mem_we ##1 acc_q == $past(mem_rd) - 8'h01)
		else $error("subtract one to accumulator wrong");
	AST_ADD1_ACC: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::ADD_ONE_TO_ACC |=> acc_q == $past(mem_rd) + 8'h01)
		else $error("add one to accumulator wrong");
	AST_SLEEP_ENTRY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::POWER_DOWN && !wdt_timeout_i
		|=> sleep_o && pdf_q && !to_q && wdt_clear_o && !ready_o)
		else $error("power-down entry wrong");
	AST_SLEEP_HOLD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_q == ieu_pkg::ST_SLEEP && !wake |=> $stable(acc_q) && $stable(pc_q) && sleep_o)
		else $error("state changed while asleep");
	AST_BRANCH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::BRANCH_ABSOLUTE
		|=> pc_o == $past(instr_target_i) && !ready_o ##1 ready_o)
		else $error("branch timing or target wrong");
	AST_IDLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::IDLE_INSTRUCTION
		|=> pc_q == $past(pc_q) + 11'h001 && $stable(acc_q) && $stable(z_q) && ready_o)
		else $error("idle instruction changed state");
	AST_OR_IMM: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::OR_IMM_TO_ACC |=> acc_q == ($past(acc_q) | $past(instr_imm_i)))
		else $error("or immediate wrong");
	AST_EXIT_EMI: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::INTERRUPT_EXIT |=> emi_q && !ready_o)
		else $error("interrupt exit did not enable");
	AST_EXIT_SERVICE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		interrupt_exit_q && irq_pending_i |=> irq_ack_o && pc_q == `IEU_IRQ_VECTOR && !emi_q)
		else $error("pending interrupt not serviced");
	AST_ROTATE_ACC: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		take && op == ieu_pkg::ROTATE_LEFT_TO_ACC
		|-> !mem_we ##1 acc_q == {$past(mem_rd[6:0]), $past(mem_rd[7])})
		else $error("rotate to accumulator wrong");
endmodule // ieu_core
`default_nettype wire

// >>> pkg/ieu_consts.svh
// Offsets, field positions, reset values and constants of the instruction execute unit
`ifndef IEU_CONSTS_SVH
`define IEU_CONSTS_SVH
`define IEU_REG_STATUS   3'h0
`define IEU_REG_ACC      3'h1
`define IEU_REG_PC_LO    3'h2
`define IEU_REG_PC_HI    3'h3
`define IEU_REG_CTRL     3'h4
`define IEU_ST_Z         0
`define IEU_ST_C         1
`define IEU_ST_AC        2
`define IEU_ST_TO        3
`define IEU_ST_PDF       4
`define IEU_ST_EMI       5
`define IEU_CTRL_WAKE    0
`define IEU_CTRL_READY   1
`define IEU_ACC_RST      8'h00
`define IEU_PC_RST       11'h000
`define IEU_IRQ_VECTOR   11'h004
`define IEU_DAA_LIMIT    4'h9
`define IEU_DAA_FIX      4'h6
`define IEU_STACK_DEPTH  6
`define IEU_MEM_WORDS    96
`endif

// >>> pkg/ieu_pkg.sv
// Types of the instruction execute unit
package ieu_pkg;
	typedef enum logic [4:0] {
		IDLE_INSTRUCTION      = 5'h00,
		INVERT_MEMORY         = 5'h01,
		INVERT_TO_ACCUMULATOR = 5'h02,
		DECIMAL_ADJUST        = 5'h03,
		SUBTRACT_ONE_MEMORY   = 5'h04,
		SUBTRACT_ONE_TO_ACC   = 5'h05,
		ADD_ONE_MEMORY        = 5'h06,
		ADD_ONE_TO_ACC        = 5'h07,
		POWER_DOWN            = 5'h08,
		BRANCH_ABSOLUTE       = 5'h09,
		COPY_MEM_TO_ACC       = 5'h0A,
		COPY_IMM_TO_ACC       = 5'h0B,
		COPY_ACC_TO_MEM       = 5'h0C,
		OR_MEM_TO_ACC         = 5'h0D,
		OR_IMM_TO_ACC         = 5'h0E,
		OR_INTO_MEMORY        = 5'h0F,
		POP_TO_COUNTER        = 5'h10,
		POP_LOAD_ACC          = 5'h11,
		INTERRUPT_EXIT        = 5'h12,
		ROTATE_LEFT           = 5'h13,
		ROTATE_LEFT_TO_ACC    = 5'h14
	} ieu_op_t;
	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_DUMMY = 2'b01,
		ST_SLEEP = 2'b11
	} ieu_state_t;
endpackage

// >>> logic/ieu_dmem.sv
// Data memory of the core: 96 bytes, one write port, combinational read
`timescale 1ns/1ps
`default_nettype none
`include "ieu_consts.svh"
module ieu_dmem (
	input  wire logic       sys_clk_i,
	input  wire logic [6:0] addr_i,
	input  wire logic       we_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);
	logic [7:0] mem [0:`IEU_MEM_WORDS-1];

	// Addresses past the top read zero and drop writes
	always_ff @(posedge sys_clk_i) begin
		if (we_i && (32'(addr_i) < `IEU_MEM_WORDS)) begin
			mem[addr_i] <= wdata_i;
		end
	end

	always_comb begin
		rdata_o = (32'(addr_i) < `IEU_MEM_WORDS) ? mem[addr_i] : 8'h00;
	end
endmodule // ieu_dmem
`default_nettype wire

// >>> logic/ieu_stack.sv
// Return address stack, six levels of 11 bits
`timescale 1ns/1ps
`default_nettype none
`include "ieu_consts.svh"
module ieu_stack (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic        push_i,
	input  wire logic        pop_i,
	input  wire logic [10:0] push_data_i,
	output logic      [10:0] top_o
);
	logic [10:0] entry_q [0:`IEU_STACK_DEPTH-1];
	logic [2:0]  ptr_q;

	// Ptr counts entries; it wraps like the real stack and never blocks
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			ptr_q <= 3'h0;
		end else if (push_i) begin
			ptr_q <= (ptr_q == 3'(`IEU_STACK_DEPTH - 1)) ? 3'h0 : ptr_q + 3'h1;
		end else if (pop_i) begin
			ptr_q <= (ptr_q == 3'h0) ? 3'(`IEU_STACK_DEPTH - 1) : ptr_q - 3'h1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (push_i) begin
			entry_q[ptr_q] <= push_data_i;
		end
	end

	always_comb begin
		top_o = entry_q[(ptr_q == 3'h0) ? 3'(`IEU_STACK_DEPTH - 1) : ptr_q - 3'h1];
	end
endmodule // ieu_stack
`default_nettype wire

// >>> testbench/ieu_testbench.sv
// Self-checking testbench for the instruction execute unit
`timescale 1ns/1ps
`default_nettype none
`include "ieu_consts.svh"
module testbench;
	logic        sys_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        instr_valid_i = 1'b0;
	logic [4:0]  instr_op_i = 5'h00;
	logic [6:0]  instr_addr_i = 7'h00;
	logic [7:0]  instr_imm_i = 8'h00;
	logic [10:0] instr_target_i = 11'h000;
	logic        irq_pending_i = 1'b0;
	logic        wdt_timeout_i = 1'b0;
	logic [2:0]  reg_addr_i = 3'h0;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [7:0]  reg_rdata_o;
	logic        ready_o;
	logic [10:0] pc_o;
	logic [7:0]  acc_o;
	logic        sleep_o;
	logic        wdt_clear_o;
	logic        irq_ack_o;
	int          n_mismatch = 0;
	int          total_checks = 0;
	integer      seed = 24;
	logic [7:0]  exp_q[$];
	logic        rd_pend = 1'b0;
	logic [7:0]  mem_m[96];
	logic [7:0]  acc_m = 8'h00;
	logic [10:0] pc_m = 11'h000;
	logic        z_m, c_m, ac_m, to_m, pdf_m, emi_m;

	always #20 sys_clk_i = ~sys_clk_i;

	ieu_core uut (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
		.instr_addr_i(instr_addr_i), .instr_imm_i(instr_imm_i),
		.instr_target_i(instr_target_i), .irq_pending_i(irq_pending_i),
		.wdt_timeout_i(wdt_timeout_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .ready_o(ready_o), .pc_o(pc_o), .acc_o(acc_o),
		.sleep_o(sleep_o), .wdt_clear_o(wdt_clear_o), .irq_ack_o(irq_ack_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s: got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic close_out();
		$display("Mismatches %0d, checks %0d", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Read data stands only in the cycle after the strobe, so look at mid-cycle
	always @(posedge sys_clk_i)
		rd_pend <= reg_rd_i;
	always @(negedge sys_clk_i) begin
		if (rd_pend) begin
			if (exp_q.size() == 0)
				cmp_val(16'h0000, 16'hFFFF, "read without note");
			else
				cmp_val({8'h00, reg_rdata_o}, {8'h00, exp_q.pop_front()}, "read data");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		exp_q.push_back(e);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic exec(input ieu_pkg::ieu_op_t op, input logic [6:0] a, input logic [7:0] x,
		input logic [10:0] t);
		@(posedge sys_clk_i);
		instr_valid_i <= 1'b1;
		instr_op_i <= op;
		instr_addr_i <= a;
		instr_imm_i <= x;
		instr_target_i <= t;
		@(posedge sys_clk_i);
		instr_valid_i <= 1'b0;
	endtask

	// Reference behaviour of the single-cycle data instructions
	task automatic mstep(input ieu_pkg::ieu_op_t op, input logic [6:0] a, input logic [7:0] x);
		logic [7:0] v;
		logic [8:0] s;
		logic       lf;
		logic       hf;
		v = mem_m[a];
		lf = (acc_m[3:0] > 4'h9) || ac_m;
		hf = (acc_m[7:4] > 4'h9) || c_m;
		s = {1'b0, acc_m} + {1'b0, (hf ? 4'h6 : 4'h0), (lf ? 4'h6 : 4'h0)};
		case (op)
			ieu_pkg::INVERT_MEMORY, ieu_pkg::INVERT_TO_ACCUMULATOR: v = ~v;
			ieu_pkg::SUBTRACT_ONE_MEMORY, ieu_pkg::SUBTRACT_ONE_TO_ACC: v = v - 8'h01;
			ieu_pkg::ADD_ONE_MEMORY, ieu_pkg::ADD_ONE_TO_ACC: v = v + 8'h01;
			ieu_pkg::OR_MEM_TO_ACC, ieu_pkg::OR_INTO_MEMORY: v = v | acc_m;
			ieu_pkg::OR_IMM_TO_ACC: v = x | acc_m;
			ieu_pkg::ROTATE_LEFT, ieu_pkg::ROTATE_LEFT_TO_ACC: v = {v[6:0], v[7]};
			ieu_pkg::COPY_IMM_TO_ACC: v = x;
			ieu_pkg::COPY_ACC_TO_MEM: v = acc_m;
			ieu_pkg::DECIMAL_ADJUST: v = s[7:0];
			default: ;
		endcase
		if (op inside {[5'h01:5'h02], [5'h04:5'h07], [5'h0D:5'h0F]})
			z_m = (v == 8'h00);
		if (op inside {5'h01, 5'h03, 5'h04, 5'h06, 5'h0C, 5'h0F, 5'h13})
			mem_m[a] = v;
		else if (op != ieu_pkg::IDLE_INSTRUCTION)
			acc_m = v;
		if (op == ieu_pkg::DECIMAL_ADJUST)
			c_m = c_m | hf | s[8];
		pc_m = pc_m + 11'h001;
	endtask

	task automatic run(input ieu_pkg::ieu_op_t op, input logic [6:0] a, input logic [7:0] x);
		exec(op, a, x, 11'h000);
		mstep(op, a, x);
	endtask

	task automatic chk_state();
		@(negedge sys_clk_i);
		cmp_val({8'h00, acc_o}, {8'h00, acc_m}, "acc port");
		rd(`IEU_REG_STATUS, {2'b00, emi_m, pdf_m, to_m, ac_m, c_m, z_m});
		rd(`IEU_REG_ACC, acc_m);
		rd(`IEU_REG_PC_LO, pc_m[7:0]);
		rd(`IEU_REG_PC_HI, {5'h00, pc_m[10:8]});
	endtask

	task automatic jump(input logic [10:0] t);
		exec(ieu_pkg::BRANCH_ABSOLUTE, 7'h00, 8'h00, t);
		@(negedge sys_clk_i);
		cmp_val({5'h00, pc_o}, {5'h00, t}, "branch target");
		cmp_bit(ready_o, 1'b0, "dummy cycle");
		@(negedge sys_clk_i);
		cmp_bit(ready_o, 1'b1, "ready after branch");
		pc_m = t;
	endtask

	task automatic two_cycle(input ieu_pkg::ieu_op_t op, input logic [7:0] x, input logic ack);
		exec(op, 7'h00, x, 11'h000);
		@(negedge sys_clk_i);
		cmp_bit(ready_o, 1'b0, "second cycle");
		@(negedge sys_clk_i);
		cmp_bit(ready_o, 1'b1, "ready again");
		cmp_bit(irq_ack_o, ack, "irq taken");
		if (ack)
			cmp_val({5'h00, pc_o}, {5'h00, `IEU_IRQ_VECTOR}, "vector");
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (ready_o !== 1'b1 && n < 8) begin
			@(negedge sys_clk_i);
			n++;
		end
		cmp_bit(ready_o, 1'b1, "wake");
		cmp_bit(sleep_o, 1'b0, "awake");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(40 * 20000);
		n_mismatch++;
		$display("[ERR] %0t run did not finish", $time);
		close_out();
	end

	initial begin
		ieu_pkg::ieu_op_t op;
		logic [6:0]       a;
		logic [7:0]       m;
		logic [7:0]       r;
		{emi_m, pdf_m, to_m, ac_m, c_m, z_m} = 6'h00;
		repeat (8) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(`IEU_REG_CTRL, 8'h02);
		for (int u = 5; u < 8; u++)
			rd(3'(u), 8'h00);
		// Read-only and unmapped places must ignore writes
		wr(`IEU_REG_ACC, 8'h5A);
		wr(3'h7, 8'hFF);
		chk_state();
		for (int it = 0; it < 8; it++) begin
			for (int k = 0; k < 21; k++) begin
				if (k inside {8, 9, 16, 17, 18})
					continue;
				op = ieu_pkg::ieu_op_t'(k[4:0]);
				a = 7'($unsigned($random(seed)) % 96);
				m = (it == 0) ? 8'hFF : (it == 1) ? 8'h00 : (it == 2) ? 8'h01 : 8'($random(seed));
				run(ieu_pkg::COPY_IMM_TO_ACC, a, m);
				run(ieu_pkg::COPY_ACC_TO_MEM, a, 8'h00);
				run(ieu_pkg::COPY_IMM_TO_ACC, a, (it < 2) ? 8'h00 : 8'($random(seed)));
				r = 8'($random(seed));
				wr(`IEU_REG_STATUS, r);
				{emi_m, ac_m, c_m, z_m} = {r[5], r[2:0]};
				run(op, a, 8'($random(seed)));
				chk_state(); // Flags and acc
				run(ieu_pkg::COPY_MEM_TO_ACC, a, 8'h00);
				rd(`IEU_REG_ACC, acc_m); // Memory byte
				chk_state(); // Copy back
			end
		end
		// Only the low nibble is out of range, so only 06 is added and carry stays clear
		run(ieu_pkg::COPY_IMM_TO_ACC, 7'h10, 8'h8A);
		wr(`IEU_REG_STATUS, 8'h00);
		{emi_m, ac_m, c_m, z_m} = 4'h0;
		run(ieu_pkg::DECIMAL_ADJUST, 7'h10, 8'h00);
		run(ieu_pkg::COPY_MEM_TO_ACC, 7'h10, 8'h00);
		chk_state();
		cmp_val({8'h00, acc_o}, 16'h0090, "decimal adjust value");
		// Counter wraps from the top address
		jump(11'h7FF);
		run(ieu_pkg::IDLE_INSTRUCTION, 7'h00, 8'h00);
		chk_state();
		@(posedge sys_clk_i);
		wdt_timeout_i <= 1'b1;
		@(posedge sys_clk_i);
		wdt_timeout_i <= 1'b0;
		to_m = 1'b1;
		chk_state();
		for (int w = 0; w < 2; w++) begin
			exec(ieu_pkg::POWER_DOWN, 7'h00, 8'h00, 11'h000);
			@(negedge sys_clk_i);
			cmp_bit(sleep_o, 1'b1, "asleep");
			cmp_bit(wdt_clear_o, 1'b1, "watchdog clear");
			cmp_bit(ready_o, 1'b0, "halted");
			exec(ieu_pkg::ADD_ONE_TO_ACC, 7'h00, 8'h00, 11'h000);
			@(negedge sys_clk_i);
			cmp_bit(wdt_clear_o, 1'b0, "clear pulse");
			rd(`IEU_REG_CTRL, 8'h01);
			if (w == 0) begin
				wr(`IEU_REG_CTRL, 8'h01);
			end else begin
				@(posedge sys_clk_i);
				irq_pending_i <= 1'b1;
				@(posedge sys_clk_i);
				irq_pending_i <= 1'b0;
			end
			wait_ready();
			{pdf_m, to_m} = 2'b10;
			jump(11'($random(seed)));
			chk_state(); // Contents kept across sleep
		end
		wr(`IEU_REG_STATUS, 8'h07);
		{emi_m, ac_m, c_m, z_m} = 4'h7;
		r = 8'($random(seed));
		two_cycle(ieu_pkg::POP_TO_COUNTER, 8'h00, 1'b0);
		two_cycle(ieu_pkg::POP_LOAD_ACC, r, 1'b0);
		acc_m = r;
		two_cycle(ieu_pkg::INTERRUPT_EXIT, 8'h00, 1'b0);
		emi_m = 1'b1;
		jump(11'($random(seed)));
		chk_state();
		wr(`IEU_REG_STATUS, 8'h00);
		{emi_m, ac_m, c_m, z_m} = 4'h0;
		@(posedge sys_clk_i);
		irq_pending_i <= 1'b1;
		two_cycle(ieu_pkg::INTERRUPT_EXIT, 8'h00, 1'b1);
		@(posedge sys_clk_i);
		irq_pending_i <= 1'b0;
		pc_m = `IEU_IRQ_VECTOR;
		chk_state();
		repeat (2) @(posedge sys_clk_i);
		close_out();
	end
endmodule // testbench
`default_nettype wire
